// *** rtl/exec_core.sv ***
// execution unit for an or, stack, return, rotate, set, jump, subtract slice
//
// Functional notes
// - or source into destination, source kept
// - result bit set when either bit set
// - pop copies stack byte, then decrements pointer
// - stack operand is always a direct address
// - push increments pointer, then stores direct byte
// - subroutine return pops high then low byte
// - interrupt return releases priority, then pops
// - outside service it equals subroutine return
// - rotate left, bit 7 into bit 0
// - rotate left through carry
// - rotate right, flags untouched
// - rotate right through carry
// - set carry or the addressed bit
// - short jump adds signed offset to next address
// - subtract operand from accumulator, operand kept
// - carry flag is borrow out of bit 7
// - auxiliary carry is borrow from bit 3
// - overflow is borrow 6 xor borrow 7
// - swap accumulator nibbles
`timescale 1ns/1ps
module exec_core
  import exec_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // program memory, combinational read
  output logic [15:0] codeAddr,
  output logic codeRd,
  input wire logic [7:0] codeData,
  // interrupt controller
  input wire logic irqEnterHigh,
  input wire logic irqEnterLow,
  output logic inServiceHigh,
  output logic inServiceLow,
  // core state
  output logic [15:0] pcOut,
  output logic [7:0] accOut,
  output logic [7:0] pswOut,
  output logic [7:0] spOut,
  output logic instrDone,
  output logic illegalOp
);

  typedef struct packed {
    exec_state_t state;
    logic [15:0] pc;
    logic [7:0] acc;
    logic [7:0] psw;
    logic [7:0] sp;
    logic [7:0] opcode;
    logic [7:0] op1;
    logic [7:0] op2;
    logic [7:0] retHigh;
    logic [15:0] codeAddr;
    logic codeRd;
    logic inSvcHigh;
    logic inSvcLow;
    logic done;
    logic illegal;
  } core_t;

  core_t coreReg;
  core_t coreNext;
  op_class_t opClass;
  logic [7:0] ramAddrA;
  logic [7:0] ramDataA;
  logic [7:0] ramDataB;
  logic [7:0] dirA;
  logic [7:0] srcVal;
  logic wrEn;
  logic wrRaw;
  logic popDec;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic ramWe;
  alu_op_t aluOp;
  logic [7:0] aluA;
  logic [7:0] aluB;
  logic [7:0] aluRes;
  logic aluC;
  logic aluAc;
  logic aluOv;
  logic bitVal;

  assign opClass = classify(coreReg.opcode);

  // port A address; register forms go through the selected bank
  always_comb begin
    ramAddrA = coreReg.op1;
    unique case (opClass)
      CL_OR_ACC, CL_SUB: begin
        if (coreReg.opcode[3:0] == SRC_DIRECT) begin
          ramAddrA = coreReg.op1;
        end else if (coreReg.opcode[3]) begin
          ramAddrA = regAddr(coreReg.psw, coreReg.opcode[2:0]);
        end else begin
          ramAddrA = regAddr(coreReg.psw, {2'b00, coreReg.opcode[0]});
        end
      end
      CL_POP, CL_RET, CL_INTERRUPT_RETURN_OP: ramAddrA = coreReg.sp;
      CL_OR_C, CL_SET_BIT: ramAddrA = bitByteAddr(coreReg.op1);
      default: ramAddrA = coreReg.op1;
    endcase
  end

  // core registers answer their own direct addresses
  always_comb begin
    if (ramAddrA == SFR_ACC) begin
      dirA = coreReg.acc;
    end else if (ramAddrA == SFR_PSW) begin
      dirA = coreReg.psw;
    end else if (ramAddrA == SFR_SP) begin
      dirA = coreReg.sp;
    end else begin
      dirA = ramDataA;
    end
  end

  // source operand of accumulator forms; indirect goes through port B
  always_comb begin
    unique case (coreReg.opcode[3:0])
      SRC_IMM: srcVal = coreReg.op1;
      4'h6, 4'h7: srcVal = ramDataB;
      default: srcVal = dirA;
    endcase
  end

  assign bitVal = dirA[coreReg.op1[2:0]];

  // alu operand and operation select
  always_comb begin
    aluA = coreReg.acc;
    aluB = srcVal;
    aluOp = ALU_PASS;
    unique case (opClass)
      CL_OR_DIR: begin
        aluA = dirA;
        aluB = (coreReg.opcode == OPC_OR_DIR_A) ? coreReg.acc : coreReg.op2;
        aluOp = ALU_OR;
      end
      CL_OR_ACC: aluOp = ALU_OR;
      CL_SUB: aluOp = ALU_SUB;
      CL_SWAP: aluOp = ALU_SWAP;
      CL_ROT: begin
        unique case (coreReg.opcode)
          OPC_ROT_L: aluOp = ALU_RL;
          OPC_ROT_LC: aluOp = ALU_RLC;
          OPC_ROT_R: aluOp = ALU_RR;
          default: aluOp = ALU_RRC;
        endcase
      end
      default: aluOp = ALU_PASS;
    endcase
  end

  exec_alu u_alu (
    .aluOp(aluOp),
    .opA(aluA),
    .opB(aluB),
    .carryIn(coreReg.psw[PSW_C]),
    .result(aluRes),
    .carryOut(aluC),
    .auxOut(aluAc),
    .ovOut(aluOv)
  );

  data_space u_data (
    .clk_sys(clk_sys),
    .wrEn(ramWe),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .rdAddrA(ramAddrA),
    .rdDataA(ramDataA),
    .rdAddrB(ramDataA),
    .rdDataB(ramDataB)
  );

  // sequencer: fetch opcode and operands, then execute
  always_comb begin
    coreNext = coreReg;
    coreNext.codeRd = 1'b0;
    coreNext.done = 1'b0;
    coreNext.illegal = 1'b0;
    wrEn = 1'b0;
    wrRaw = 1'b0;
    popDec = 1'b0;
    wrAddr = RESET_BYTE;
    wrData = RESET_BYTE;
    unique case (coreReg.state)
      ST_FETCH: begin
        coreNext.codeAddr = coreReg.pc;
        coreNext.codeRd = 1'b1;
        coreNext.state = ST_OPCODE;
      end
      ST_OPCODE: begin
        coreNext.opcode = codeData;
        coreNext.pc = coreReg.pc + 16'h0001;
        if (opLength(codeData) != 2'd1) begin
          coreNext.codeAddr = coreReg.pc + 16'h0001;
          coreNext.codeRd = 1'b1;
          coreNext.state = ST_OPER1;
        end else begin
          coreNext.state = ST_EXEC;
        end
      end
      ST_OPER1: begin
        coreNext.op1 = codeData;
        coreNext.pc = coreReg.pc + 16'h0001;
        if (opLength(coreReg.opcode) == 2'd3) begin
          coreNext.codeAddr = coreReg.pc + 16'h0001;
          coreNext.codeRd = 1'b1;
          coreNext.state = ST_OPER2;
        end else begin
          coreNext.state = ST_EXEC;
        end
      end
      ST_OPER2: begin
        coreNext.op2 = codeData;
        coreNext.pc = coreReg.pc + 16'h0001;
        coreNext.state = ST_EXEC;
      end
      ST_EXEC: begin
        coreNext.state = ST_FETCH;
        coreNext.done = 1'b1;
        unique case (opClass)
          CL_OR_DIR: begin
            wrEn = 1'b1;
            wrAddr = coreReg.op1;
            wrData = aluRes;
          end
          CL_OR_ACC, CL_SUB, CL_ROT, CL_SWAP: begin
            coreNext.acc = aluRes;
            coreNext.psw[PSW_C] = aluC;
            if (opClass == CL_SUB) begin
              coreNext.psw[PSW_AC] = aluAc;
              coreNext.psw[PSW_OV] = aluOv;
            end
          end
          CL_OR_C: begin
            // inverted form uses the complement, bit itself untouched
            coreNext.psw[PSW_C] = coreReg.psw[PSW_C] |
              ((coreReg.opcode == OPC_OR_C_NBIT) ? ~bitVal : bitVal);
          end
          CL_POP: begin
            wrEn = 1'b1;
            wrAddr = coreReg.op1;
            wrData = ramDataA;
            popDec = 1'b1;
            coreNext.sp = coreReg.sp - 8'h01;
          end
          CL_PUSH: begin
            coreNext.sp = coreReg.sp + 8'h01;
            wrEn = 1'b1;
            wrRaw = 1'b1;
            wrAddr = coreReg.sp + 8'h01;
            wrData = dirA;
          end
          CL_RET, CL_INTERRUPT_RETURN_OP: begin
            // high byte comes off first
            coreNext.retHigh = ramDataA;
            coreNext.sp = coreReg.sp - 8'h01;
            coreNext.state = ST_POP_LOW;
            coreNext.done = 1'b0;
            if (opClass == CL_INTERRUPT_RETURN_OP) begin
              // release the highest level in service; none means plain return
              if (coreReg.inSvcHigh) begin
                coreNext.inSvcHigh = 1'b0;
              end else begin
                coreNext.inSvcLow = 1'b0;
              end
            end
          end
          CL_SET_C: coreNext.psw[PSW_C] = 1'b1;
          CL_SET_BIT: begin
            wrEn = 1'b1;
            wrAddr = bitByteAddr(coreReg.op1);
            wrData = dirA | (8'h01 << coreReg.op1[2:0]);
          end
          CL_JUMP: begin
            coreNext.pc = coreReg.pc + {{8{coreReg.op1[7]}}, coreReg.op1};
          end
          default: coreNext.illegal = 1'b1;
        endcase
      end
      ST_POP_LOW: begin
        coreNext.pc = {coreReg.retHigh, ramDataA};
        coreNext.sp = coreReg.sp - 8'h01;
        coreNext.done = 1'b1;
        coreNext.state = ST_FETCH;
      end
    endcase
    // direct writes to core registers land here, not in the array
    if (wrEn && !wrRaw) begin
      if (wrAddr == SFR_ACC) begin
        coreNext.acc = wrData;
      end else if (wrAddr == SFR_PSW) begin
        coreNext.psw = wrData;
      end else if (wrAddr == SFR_SP) begin
        // pop into the pointer still decrements after the copy
        coreNext.sp = popDec ? wrData - 8'h01 : wrData;
      end
    end
    // entry beats release in the same cycle so no level is lost
    if (irqEnterHigh) begin
      coreNext.inSvcHigh = 1'b1;
    end
    if (irqEnterLow) begin
      coreNext.inSvcLow = 1'b1;
    end
  end

  // stack stores bypass core registers so the pointer cannot clobber them
  assign ramWe = wrEn && (wrRaw || !isCoreSfr(wrAddr));

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      coreReg <= '{state: ST_FETCH, pc: RESET_PC, acc: RESET_BYTE,
                   psw: RESET_BYTE, sp: RESET_SP, opcode: RESET_BYTE,
                   op1: RESET_BYTE, op2: RESET_BYTE, retHigh: RESET_BYTE,
                   codeAddr: RESET_PC, default: 1'b0};
    end else begin
      coreReg <= coreNext;
    end
  end

  // outputs straight from the state register
  assign codeAddr = coreReg.codeAddr;
  assign codeRd = coreReg.codeRd;
  assign inServiceHigh = coreReg.inSvcHigh;
  assign inServiceLow = coreReg.inSvcLow;
  assign pcOut = coreReg.pc;
  assign accOut = coreReg.acc;
  assign pswOut = coreReg.psw;
  assign spOut = coreReg.sp;
  assign instrDone = coreReg.done;
  assign illegalOp = coreReg.illegal;

endmodule

// *** rtl/exec_pkg.sv ***
// shared constants, types and decode helpers for the execution slice
package exec_pkg;

  // opcodes handled by this slice
  localparam logic [7:0] OPC_OR_DIR_A = 8'h42;
  localparam logic [7:0] OPC_OR_DIR_IMM = 8'h43;
  localparam logic [7:0] OPC_OR_C_BIT = 8'h72;
  localparam logic [7:0] OPC_OR_C_NBIT = 8'hA0;
  localparam logic [7:0] OPC_POP = 8'hD0;
  localparam logic [7:0] OPC_PUSH = 8'hC0;
  localparam logic [7:0] OPC_SUB_RET = 8'h22;
  localparam logic [7:0] OPC_INT_RET = 8'h32;
  localparam logic [7:0] OPC_ROT_L = 8'h23;
  localparam logic [7:0] OPC_ROT_LC = 8'h33;
  localparam logic [7:0] OPC_ROT_R = 8'h03;
  localparam logic [7:0] OPC_ROT_RC = 8'h13;
  localparam logic [7:0] OPC_SET_C = 8'hD3;
  localparam logic [7:0] OPC_SET_BIT = 8'hD2;
  localparam logic [7:0] OPC_SHORT_JUMP = 8'h80;
  localparam logic [7:0] OPC_NIB_SWAP = 8'hC4;
  localparam logic [3:0] OPC_OR_HI = 4'h4;
  localparam logic [3:0] OPC_SUB_HI = 4'h9;
  localparam logic [3:0] OPC_FIRST_ACC_SRC = 4'h4;
  localparam logic [3:0] SRC_IMM = 4'h4;
  localparam logic [3:0] SRC_DIRECT = 4'h5;

  // core special registers held inside the slice, then the base of the bit ram
  localparam logic [7:0] SFR_ACC = 8'hE0;
  localparam logic [7:0] SFR_PSW = 8'hD0;
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;

  // flag word layout
  localparam int PSW_C = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_OV = 2;
  localparam int PSW_BANK_LO = 3;

  // reset values
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [7:0] RESET_SP = 8'h07;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [2:0] {
    ALU_PASS, ALU_OR, ALU_SUB, ALU_RL, ALU_RLC, ALU_RR, ALU_RRC, ALU_SWAP
  } alu_op_t;

  typedef enum logic [3:0] {
    CL_OR_DIR, CL_OR_ACC, CL_OR_C, CL_POP, CL_PUSH, CL_RET, CL_INTERRUPT_RETURN_OP,
    CL_ROT, CL_SET_C, CL_SET_BIT, CL_JUMP, CL_SUB, CL_SWAP, CL_NONE
  } op_class_t;

  typedef enum logic [2:0] {
    ST_FETCH, ST_OPCODE, ST_OPER1, ST_OPER2, ST_EXEC, ST_POP_LOW
  } exec_state_t;

  // sort an opcode into its execution class
  function automatic op_class_t classify(input logic [7:0] op);
    op_class_t c;
    c = CL_NONE;
    if (op == OPC_OR_DIR_A || op == OPC_OR_DIR_IMM) c = CL_OR_DIR;
    else if (op[7:4] == OPC_OR_HI && op[3:0] >= OPC_FIRST_ACC_SRC)
      c = CL_OR_ACC;
    else if (op[7:4] == OPC_SUB_HI && op[3:0] >= OPC_FIRST_ACC_SRC)
      c = CL_SUB;
    else if (op == OPC_OR_C_BIT || op == OPC_OR_C_NBIT) c = CL_OR_C;
    else if (op == OPC_POP) c = CL_POP;
    else if (op == OPC_PUSH) c = CL_PUSH;
    else if (op == OPC_SUB_RET) c = CL_RET;
    else if (op == OPC_INT_RET) c = CL_INTERRUPT_RETURN_OP;
    else if (op == OPC_ROT_L || op == OPC_ROT_LC || op == OPC_ROT_R ||
             op == OPC_ROT_RC) c = CL_ROT;
    else if (op == OPC_SET_C) c = CL_SET_C;
    else if (op == OPC_SET_BIT) c = CL_SET_BIT;
    else if (op == OPC_SHORT_JUMP) c = CL_JUMP;
    else if (op == OPC_NIB_SWAP) c = CL_SWAP;
    return c;
  endfunction

  // instruction length in bytes, opcode included
  function automatic logic [1:0] opLength(input logic [7:0] op);
    op_class_t c;
    c = classify(op);
    if (op == OPC_OR_DIR_IMM) return 2'd3;
    if (c == CL_OR_ACC || c == CL_SUB)
      return (op[3:0] <= SRC_DIRECT) ? 2'd2 : 2'd1;
    if (c == CL_OR_DIR || c == CL_OR_C || c == CL_POP || c == CL_PUSH ||
        c == CL_SET_BIT || c == CL_JUMP) return 2'd2;
    return 2'd1;
  endfunction

  // address of bank register n in the selected bank
  function automatic logic [7:0] regAddr(input logic [7:0] psw,
                                         input logic [2:0] n);
    return {3'b000, psw[PSW_BANK_LO+1 -: 2], n};
  endfunction

  // byte that holds a bit address
  function automatic logic [7:0] bitByteAddr(input logic [7:0] b);
    return b[7] ? {b[7:3], 3'b000} : BIT_RAM_BASE + {4'h0, b[6:3]};
  endfunction

  // registers that live in the core rather than in the data array
  function automatic logic isCoreSfr(input logic [7:0] a);
    return a == SFR_ACC || a == SFR_PSW || a == SFR_SP;
  endfunction

endpackage

// *** rtl/exec_alu.sv ***
// combinational byte arithmetic for or, subtract, rotate and swap
`timescale 1ns/1ps
module exec_alu
  import exec_pkg::*;
(
  // operation select and operands
  input wire alu_op_t aluOp,
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic carryIn,
  // result and flags
  output logic [7:0] result,
  output logic carryOut,
  output logic auxOut,
  output logic ovOut
);

  logic [4:0] lowDiff;
  logic [7:0] sevenDiff;
  logic [8:0] fullDiff;

  // borrow chains; the incoming carry is the borrow
  assign lowDiff = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, carryIn};
  assign sevenDiff = {1'b0, opA[6:0]} - {1'b0, opB[6:0]} - {7'h00, carryIn};
  assign fullDiff = {1'b0, opA} - {1'b0, opB} - {8'h00, carryIn};

  // carry holds unless the operation defines it; aux and overflow default to zero
  always_comb begin
    result = opA;
    carryOut = carryIn;
    auxOut = 1'b0;
    ovOut = 1'b0;
    unique case (aluOp)
      ALU_PASS: result = opA;
      ALU_OR: result = opA | opB;
      ALU_SUB: begin
        result = fullDiff[7:0];
        carryOut = fullDiff[8];
        auxOut = lowDiff[4];
        ovOut = sevenDiff[7] ^ fullDiff[8];
      end
      ALU_RL: result = {opA[6:0], opA[7]};
      ALU_RLC: begin
        result = {opA[6:0], carryIn};
        carryOut = opA[7];
      end
      ALU_RR: result = {opA[0], opA[7:1]};
      ALU_RRC: begin
        result = {carryIn, opA[7:1]};
        carryOut = opA[0];
      end
      ALU_SWAP: result = {opA[3:0], opA[7:4]};
    endcase
  end

endmodule

// *** rtl/data_space.sv ***
// 256-byte data space: internal ram and the remaining special registers
`timescale 1ns/1ps
module data_space
  import exec_pkg::*;
#(
  parameter int DEPTH = 256
) (
  // clock
  input wire logic clk_sys,
  // write port
  input wire logic wrEn,
  input wire logic [7:0] wrAddr,
  input wire logic [7:0] wrData,
  // two asynchronous read ports
  input wire logic [7:0] rdAddrA,
  output logic [7:0] rdDataA,
  input wire logic [7:0] rdAddrB,
  output logic [7:0] rdDataB
);

  logic [7:0] mem [DEPTH];

  // no reset: contents are undefined until software writes them
  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // reads are combinational so pointer chains finish in one cycle
  assign rdDataA = mem[rdAddrA];
  assign rdDataB = mem[rdAddrB];

endmodule

// *** tb/program_rom.sv ***
// program memory model with combinational read
`timescale 1ns/1ps
module program_rom (
  // clock
  input wire logic clk_sys,
  // fetch port
  input wire logic [15:0] codeAddr,
  input wire logic codeRd,
  output logic [7:0] codeData
);
  // unwritten space holds an opcode outside the slice
  logic [7:0] mem [0:4095] = '{default: 8'hA5};
  logic [7:0] last_reg = 8'h00;

  // bus shows the inverse of the last byte outside a fetch
  assign codeData = codeRd ? mem[codeAddr[11:0]] : ~last_reg;

  // remember the last byte handed out
  always_ff @(posedge clk_sys) begin
    if (codeRd) last_reg <= codeData;
  end
endmodule

// *** tb/exec_core_properties.sv ***
// port-level checks of the execution slice
`timescale 1ns/1ps
module exec_core_properties
  import exec_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // program memory
  input wire logic [15:0] codeAddr,
  input wire logic codeRd,
  input wire logic [7:0] codeData,
  // core state
  input wire logic [7:0] accOut,
  input wire logic [7:0] pswOut,
  input wire logic [7:0] spOut,
  input wire logic [15:0] pcOut,
  input wire logic instrDone,
  input wire logic illegalOp
);
  logic opNext_reg;
  logic [7:0] op_reg, arg_reg, acc_reg, psw_reg, sp_reg;
  logic [15:0] pc_reg;
  logic cIn, subEnd;
  logic [8:0] dFull, dLow, dSix;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // snapshot state at each opcode fetch, keep the last operand byte
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      opNext_reg <= 1'b1;
      op_reg <= 8'h00;
    end else begin
      if (codeRd && opNext_reg) begin
        op_reg <= codeData;
        acc_reg <= accOut;
        psw_reg <= pswOut;
        sp_reg <= spOut;
        pc_reg <= codeAddr;
      end
      if (codeRd && !opNext_reg) arg_reg <= codeData;
      if (instrDone || illegalOp) opNext_reg <= 1'b1;
      else if (codeRd) opNext_reg <= 1'b0;
    end
  end

  // reference borrows, widened so each borrow shows in the bit just above its slice
  assign cIn = psw_reg[PSW_C];
  assign subEnd = instrDone && op_reg == {OPC_SUB_HI, SRC_IMM};
  assign dFull = {1'b0, acc_reg} - {1'b0, arg_reg} - {8'h00, cIn};
  assign dLow = {5'h00, acc_reg[3:0]} - {5'h00, arg_reg[3:0]} - {8'h00, cIn};
  assign dSix = {2'b00, acc_reg[6:0]} - {2'b00, arg_reg[6:0]} - {8'h00, cIn};

  a_rot_left: assert property (
    instrDone && op_reg == OPC_ROT_L |-> accOut == {acc_reg[6:0], acc_reg[7]})
    else $error("rotate left result wrong");
  a_rot_right: assert property (
    instrDone && op_reg == OPC_ROT_R |->
    accOut == {acc_reg[0], acc_reg[7:1]} && pswOut[7:1] == psw_reg[7:1])
    else $error("rotate right result wrong");
  a_rot_carry: assert property (
    instrDone && op_reg == OPC_ROT_RC |->
    accOut == {cIn, acc_reg[7:1]} && pswOut[PSW_C] == acc_reg[0])
    else $error("rotate right through carry wrong");
  a_nib_swap: assert property (
    codeRd && opNext_reg && codeData == OPC_NIB_SWAP |=>
    !instrDone ##1 (instrDone && accOut == {acc_reg[3:0], acc_reg[7:4]}))
    else $error("nibble swap wrong or late");
  a_set_carry: assert property (
    instrDone && op_reg == OPC_SET_C |-> pswOut[PSW_C] && accOut == acc_reg)
    else $error("set carry wrong");
  a_push_incr: assert property (
    instrDone && op_reg == OPC_PUSH |-> spOut == sp_reg + 8'h01)
    else $error("push pointer wrong");
  a_pop_decr: assert property (
    instrDone && op_reg == OPC_POP && arg_reg != SFR_SP |->
    spOut == sp_reg - 8'h01)
    else $error("pop pointer wrong");
  a_jump_target: assert property (
    instrDone && op_reg == OPC_SHORT_JUMP |->
    pcOut == pc_reg + 16'h0002 + {{8{arg_reg[7]}}, arg_reg})
    else $error("short jump target wrong");
  a_sub_result: assert property (
    subEnd |-> accOut == dFull[7:0] && pswOut[PSW_C] == dFull[8])
    else $error("subtract result or carry wrong");
  a_sub_aux: assert property (
    subEnd |-> pswOut[PSW_AC] == dLow[4])
    else $error("subtract aux carry wrong");
  a_sub_over: assert property (
    subEnd |-> pswOut[PSW_OV] == (dSix[7] ^ dFull[8]))
    else $error("subtract overflow wrong");
endmodule

bind exec_core exec_core_properties chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
  .codeAddr(codeAddr), .codeRd(codeRd), .codeData(codeData), .accOut(accOut),
  .pswOut(pswOut), .spOut(spOut), .pcOut(pcOut), .instrDone(instrDone),
  .illegalOp(illegalOp));

// *** tb/tb_top.sv ***
// random program run against an integer model of the slice
`timescale 1ns/1ps
module tb_top;
  import exec_pkg::*;
  typedef struct {
    int irq;
    logic [7:0] acc, psw, sp;
    logic [15:0] pc;
    logic [1:0] svc;
  } step_t;
  logic clk_sys, rst_n, irqEnterHigh, irqEnterLow;
  logic codeRd, inServiceHigh, inServiceLow, instrDone, illegalOp;
  logic [15:0] codeAddr, pcOut;
  logic [7:0] codeData, accOut, pswOut, spOut, a, p, s, m, r;
  logic [7:0] ram [0:255];
  logic ih, il;
  int pc, dep, k, n, w, tg, errors, checked;
  integer seed;
  step_t steps[$];
  step_t e;

  exec_core dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .codeAddr(codeAddr),
    .codeRd(codeRd), .codeData(codeData), .irqEnterHigh(irqEnterHigh),
    .irqEnterLow(irqEnterLow), .inServiceHigh(inServiceHigh),
    .inServiceLow(inServiceLow), .pcOut(pcOut), .accOut(accOut),
    .pswOut(pswOut), .spOut(spOut), .instrDone(instrDone),
    .illegalOp(illegalOp));
  program_rom rom_u (.clk_sys(clk_sys), .codeAddr(codeAddr),
    .codeRd(codeRd), .codeData(codeData));

  // free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic int rnd(input int lim);
    return {$random(seed)} % lim;
  endfunction

  task automatic chk(input logic [15:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // place bytes at the model pc; stale filler is overwritten or unused
  task automatic op(input int len, input logic [7:0] b0, b1, b2);
    rom_u.mem[pc] = b0;
    rom_u.mem[pc + 1] = b1;
    if (len > 2) rom_u.mem[pc + 2] = b2;
    pc += len;
  endtask

  task automatic rec(input int irq);
    steps.push_back('{irq, a, p, s, pc[15:0], {ih, il}});
  endtask

  // borrows worked out on integers, not bit slices
  task automatic sub(input logic [7:0] b);
    int c, d;
    c = p[7];
    d = a - b - c;
    p[7] = (a < b + c);
    p[6] = ((a & 15) < (b & 15) + c);
    p[2] = p[7] ^ ((a & 127) < (b & 127) + c);
    a = d[7:0];
  endtask

  // no clear or move here, so a value is reached by subtracting
  task automatic load(input logic [7:0] v);
    m = a - v - p[7];
    op(2, 8'h94, m, 8'h00);
    sub(m);
    rec(0);
  endtask

  task automatic push();
    op(2, OPC_PUSH, SFR_ACC, 8'h00);
    s++;
    ram[s] = a;
    dep++;
    rec(0);
  endtask

  initial begin
    seed = 32'h6AD1F220;
    rst_n = 1'b0;
    irqEnterHigh = 1'b0;
    irqEnterLow = 1'b0;
    {a, p, s, pc, dep, ih, il, errors, checked} = '0;
    s = RESET_SP;
    // build the program and its expected trace during reset
    for (int i = 0; i < 200; i++) begin
      k = rnd(12);
      n = rnd(8);
      m = rnd(256);
      r = {5'h1C, m[2:0]};
      case (k)
        0: begin op(2, 8'h44, m, 8'h00); a = a | m; end
        1: begin op(2, 8'h94, m, 8'h00); sub(m); end
        2: begin
          op(1, {2'b00, n[1:0], 4'h3}, 8'hA5, 8'h00);
          case (n[1:0])
            2'd0: a = {a[0], a[7:1]};
            2'd1: {a, p[7]} = {p[7], a};
            2'd2: a = {a[6:0], a[7]};
            2'd3: {p[7], a} = {a, p[7]};
          endcase
        end
        3: begin op(1, OPC_NIB_SWAP, 8'hA5, 8'h00); a = {a[3:0], a[7:4]}; end
        4: begin
          if (n < 3) op(1, OPC_SET_C, 8'hA5, 8'h00);
          else if (n < 5) op(2, OPC_SET_BIT, 8'hD7, 8'h00);
          else op(2, OPC_SET_BIT, r, 8'h00);
          if (n < 5) p[7] = 1'b1;
          else a[m[2:0]] = 1'b1;
        end
        5: begin
          op(2, n[0] ? OPC_OR_C_NBIT : OPC_OR_C_BIT, r, 8'h00);
          p[7] = p[7] | (a[m[2:0]] ^ n[0]);
        end
        6: if (dep < 6) push();
        7: if (dep > 0) begin
          // high n pops into a bank register and reads it back
          tg = (n >= 6 && dep < 6);
          r = (n < 4) ? SFR_ACC : (tg ? {7'h00, m[0]} : {5'h00, m[2:0]});
          if (tg) begin
            load(s + 8'h01);
            push();
          end
          op(2, OPC_POP, r, 8'h00);
          if (n < 4) a = ram[s];
          else ram[r] = ram[s];
          s--;
          dep--;
          rec(0);
          if (n > 3) begin
            m = tg ? ram[ram[r]] : ram[r];
            op(1, {n[0] ? 4'h9 : 4'h4,
              tg ? {3'b011, r[0]} : {1'b1, r[2:0]}}, 8'hA5, 8'h00);
            if (n[0]) sub(m);
            else a = a | m;
            rec(0);
          end
        end
        8: if (dep > 0) begin
          if (n < 2) op(2, 8'h42, s, 8'h00);
          else if (n < 4) op(3, 8'h43, s, m);
          else if (n < 6) op(2, 8'h45, s, 8'h00);
          else op(2, 8'h95, s, 8'h00);
          if (n < 2) ram[s] = ram[s] | a;
          else if (n < 4) ram[s] = ram[s] | m;
          else if (n < 6) a = a | ram[s];
          else sub(ram[s]);
          rec(0);
        end
        9: if (dep < 5) begin
          tg = pc + 9 + n % 3;
          load(tg[7:0]);
          push();
          load(tg[15:8]);
          push();
          op(1, n[0] ? OPC_INT_RET : OPC_SUB_RET, 8'hA5, 8'h00);
          pc = tg;
          s -= 2;
          dep -= 2;
          if (n[0] && ih) ih = 1'b0;
          else if (n[0]) il = 1'b0;
          rec(0);
        end
        10: if (n[0]) begin
          m = (n[2:1] == 2'd3) ? 8'h7F : {6'h00, n[2:1]};
          op(2, OPC_SHORT_JUMP, m, 8'h00);
          pc += m;
          rec(0);
        end else begin
          // forward, backward by four, forward again over junk
          op(2, OPC_SHORT_JUMP, 8'h02, 8'h00);
          pc += 2;
          rec(0);
          op(2, OPC_SHORT_JUMP, 8'hFC, 8'h00);
          pc -= 4;
          rec(0);
          op(2, OPC_SHORT_JUMP, 8'h04, 8'h00);
          pc += 4;
          rec(0);
        end
        default: if (steps.size() > 0 && steps[$].irq == 0) begin
          if (n[0]) ih = 1'b1;
          else il = 1'b1;
          rec(n[0] ? 2 : 1);
        end
      endcase
      if (k < 6) rec(0);
    end
    // an opcode outside the slice closes the program as a no-op
    op(1, 8'hA5, 8'hA5, 8'h00);
    rec(0);
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    // replay: pulse service entries, compare state at each finish
    foreach (steps[j]) begin
      e = steps[j];
      if (e.irq != 0) begin
        @(posedge clk_sys);
        irqEnterHigh <= (e.irq == 2);
        irqEnterLow <= (e.irq == 1);
        @(posedge clk_sys);
        irqEnterHigh <= 1'b0;
        irqEnterLow <= 1'b0;
      end else begin
        w = 0;
        do begin
          @(negedge clk_sys);
          w++;
        end while (instrDone !== 1'b1 && w < 300);
        if (w >= 300) begin
          errors++;
          conclude();
        end
        chk(accOut, e.acc, "acc");
        chk(pswOut[7], e.psw[7], "c");
        chk(pswOut & 8'h5C, e.psw & 8'h5C, "psw");
        chk(spOut, e.sp, "sp");
        chk(pcOut, e.pc, "pc");
        chk({inServiceHigh, inServiceLow}, e.svc, "svc");
        chk(illegalOp, j == steps.size() - 1, "illegal");
      end
    end
    $display("test random program ends, %0d steps", steps.size());
    // reset in mid-run returns the core state to its reset values
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(negedge clk_sys);
    chk({accOut, pswOut}, 16'h0000, "reset acc psw");
    chk(spOut, RESET_SP, "reset sp");
    chk(pcOut, RESET_PC, "reset pc");
    chk({codeRd, inServiceHigh, inServiceLow}, 16'h0000, "reset ctl");
    $display("test mid-run reset ends");
    conclude();
  end
endmodule
